// [rtl/cip_defs.svh]
/*
 * constants of the key-protected configuration index/data port:
 * port addresses, keys, register indices, field positions and reset values.
 * assumes nothing; included by the port module only.
 */
`ifndef CIP_DEFS_SVH
`define CIP_DEFS_SVH

// port addresses, chosen by the address select bit
`define CIP_PORT_ADDR_SEL0   16'h03F0
`define CIP_PORT_ADDR_SEL1   16'h0370
`define CIP_DATA_ADDR_SEL0   16'h03F1
`define CIP_DATA_ADDR_SEL1   16'h0371

// keys written to the key port
`define CIP_KEY_ENTER        8'h87
`define CIP_KEY_EXIT         8'hAA

// register indices
`define CIP_IDX_SOFT_RESET   8'h02
`define CIP_IDX_LDN          8'h07
`define CIP_IDX_OPTION       8'h26
`define CIP_IDX_BANK_BASE    8'h30
`define CIP_IDX_MAX          8'hFE

// field positions
`define CIP_OPT_ADDR_SEL_BIT 6
`define CIP_OPT_LOCK_BIT     5
`define CIP_SOFT_RESET_BIT   0

// logical devices and bank geometry
`define CIP_LDN_MAX          8'h0A
`define CIP_LDN_HOLE_A       8'h04
`define CIP_LDN_HOLE_B       8'h06
`define CIP_NUM_LDN          11
`define CIP_BANK_DEPTH       207

// reset values
`define CIP_OPTION_RESET     8'h00
`define CIP_LDN_RESET        8'h00
`define CIP_BANK_RESET       8'h00
`define CIP_INDEX_RESET      8'h00

`endif

// [rtl/cip_pkg.sv]
/*
 * types of the configuration index/data port.
 * assumes nothing; takes no constants from cip_defs.svh.
 */
`default_nettype none

package cip_pkg;

	// key sequence state
	typedef enum logic [1:0] {
		CIP_ST_NORMAL = 2'b00,
		CIP_ST_KEY1   = 2'b01,
		CIP_ST_CONFIG = 2'b10
	} cip_state_e;

	// host bus pins, active high after sampling
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  data;
		logic        iow;
		logic        ior;
		logic        aen;
	} cip_pins_s;

	// slow control pins
	typedef struct packed {
		logic strap;
		logic cold;
		logic warm;
	} cip_ctl_s;

endpackage : cip_pkg

`default_nettype wire

// [rtl/cip_config_port.sv]
/*
 * key-protected index/data configuration port with global registers and
 * one register bank per logical device.
 * assumes host i/o cycles arrive as asynchronous pins, held stable for
 * several clocks; the caller resolves the data bus from isa_data_oe.
 */
// Functional notes
// - key/index port at 3F0h or 370h
// - strap latched into address select at power-on
// - two 0x87 writes enter configuration mode
// - index at key address, data at plus one
// - indices 02h and 07h-FEh select registers
// - key port is write-only, never read back
// - index write-only, data port read and write
// - index 07h then number selects device bank
// - separate bank per device from index 30h
// - device numbers 0 to A, not 4, 6
// - one 0xAA write leaves configuration mode
// - lock bit blocks configuration register access except option register 26h
// - defaults restored only by power-on or cold reset
// - warm reset keeps configuration contents
// - soft reset bit 0 of register 02h
`include "cip_defs.svh"
`default_nettype none

module cip_config_port (
	// clock and power-on reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// host i/o cycle pins
	input  wire logic [15:0] isa_addr,
	input  wire logic [7:0]  isa_data_in,
	input  wire logic        isa_iow_n,
	input  wire logic        isa_ior_n,
	input  wire logic        isa_aen,
	output logic      [7:0]  isa_data_out,
	output logic             isa_data_oe,
	// straps and reset pins
	input  wire logic        address_strap_input,
	input  wire logic        master_reset_input,
	input  wire logic        warm_reset_input,
	// status towards the rest of the chip
	output logic             config_mode,
	output logic      [7:0]  logical_device,
	output logic      [7:0]  global_option_register,
	output logic             soft_reset_pulse
);

	cip_pkg::cip_pins_s  pin_meta_ff;
	cip_pkg::cip_pins_s  pin_sync_ff;
	cip_pkg::cip_ctl_s   ctl_meta_ff;
	cip_pkg::cip_ctl_s   ctl_sync_ff;
	logic                iow_prev_ff;
	logic                ior_prev_ff;
	logic [1:0]          strap_cnt_ff;
	cip_pkg::cip_state_e state_ff;
	cip_pkg::cip_state_e nxt_state;
	logic [7:0]          index_ff;
	logic [7:0]          ldn_ff;
	logic [7:0]          option_ff;
	logic                soft_reset_ff;
	logic [7:0]          rd_data_ff;
	logic [7:0]          bank_ff [0:`CIP_NUM_LDN-1][0:`CIP_BANK_DEPTH-1];

	// pins are asynchronous: two flops before any logic looks at them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pin_meta_ff <= '0;
			pin_sync_ff <= '0;
			ctl_meta_ff <= '0;
			ctl_sync_ff <= '0;
		end else begin
			pin_meta_ff <= '{addr: isa_addr, data: isa_data_in, iow: ~isa_iow_n,
			                 ior: ~isa_ior_n, aen: isa_aen};
			pin_sync_ff <= pin_meta_ff;
			ctl_meta_ff <= '{strap: address_strap_input, cold: master_reset_input,
			                 warm: warm_reset_input};
			ctl_sync_ff <= ctl_meta_ff;
		end
	end

	// strobe edges, taken from the synchronised copies only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			iow_prev_ff <= 1'b0;
			ior_prev_ff <= 1'b0;
		end else begin
			iow_prev_ff <= pin_sync_ff.iow;
			ior_prev_ff <= pin_sync_ff.ior;
		end
	end

	// address decode follows the select bit; dma cycles (aen high) never hit
	wire        addr_sel   = option_ff[`CIP_OPT_ADDR_SEL_BIT];
	wire [15:0] port_addr  = addr_sel ? `CIP_PORT_ADDR_SEL1 : `CIP_PORT_ADDR_SEL0;
	wire [15:0] data_addr  = addr_sel ? `CIP_DATA_ADDR_SEL1 : `CIP_DATA_ADDR_SEL0;
	wire        hit_port   = !pin_sync_ff.aen && (pin_sync_ff.addr == port_addr);
	wire        hit_data   = !pin_sync_ff.aen && (pin_sync_ff.addr == data_addr);
	wire        wr_stb     = pin_sync_ff.iow && !iow_prev_ff;
	wire        rd_stb     = pin_sync_ff.ior && !ior_prev_ff;
	wire        cold_busy  = ctl_sync_ff.cold;
	wire        in_config  = (state_ff == cip_pkg::CIP_ST_CONFIG) && !cold_busy;
	wire [7:0]  wr_byte    = pin_sync_ff.data;
	wire        port_wr    = wr_stb && hit_port && !cold_busy;
	wire        data_wr    = wr_stb && hit_data && in_config;
	wire        data_rd    = rd_stb && hit_data && in_config;

	// index acceptance and bank addressing
	wire        idx_ok     = (wr_byte == `CIP_IDX_SOFT_RESET) ||
	                         ((wr_byte >= `CIP_IDX_LDN) && (wr_byte <= `CIP_IDX_MAX));
	wire        ldn_ok     = (ldn_ff <= `CIP_LDN_MAX) && (ldn_ff != `CIP_LDN_HOLE_A) &&
	                         (ldn_ff != `CIP_LDN_HOLE_B);
	wire        idx_bank   = index_ff >= `CIP_IDX_BANK_BASE;
	wire [7:0]  bank_off   = index_ff - `CIP_IDX_BANK_BASE;
	wire [3:0]  bank_sel   = ldn_ff[3:0];
	wire        bank_hit   = idx_bank && ldn_ok;
	// lock keeps the option register itself reachable, else it could never clear
	wire        locked     = option_ff[`CIP_OPT_LOCK_BIT] && (index_ff != `CIP_IDX_OPTION);
	wire        cfg_wr     = data_wr && !locked;
	wire        cfg_rd_ok  = in_config && !locked;

	// read value of the indexed register; the soft reset bit self-clears
	wire [7:0]  rd_value   = (index_ff == `CIP_IDX_LDN)    ? ldn_ff :
	                         (index_ff == `CIP_IDX_OPTION) ? option_ff :
	                         bank_hit ? bank_ff[bank_sel][bank_off] : 8'h00;

	// key sequence: two enter keys in a row, one exit key leaves
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cip_pkg::CIP_ST_NORMAL: begin
				if (port_wr && (wr_byte == `CIP_KEY_ENTER)) begin
					nxt_state = cip_pkg::CIP_ST_KEY1;
				end
			end
			cip_pkg::CIP_ST_KEY1: begin
				// any other write to the key or data address between the keys starts over
				if (port_wr && (wr_byte == `CIP_KEY_ENTER)) begin
					nxt_state = cip_pkg::CIP_ST_CONFIG;
				end else if (wr_stb && (hit_port || hit_data)) begin
					nxt_state = cip_pkg::CIP_ST_NORMAL;
				end
			end
			cip_pkg::CIP_ST_CONFIG: begin
				if (port_wr && (wr_byte == `CIP_KEY_EXIT)) begin
					nxt_state = cip_pkg::CIP_ST_NORMAL;
				end
			end
			default: begin
				nxt_state = cip_pkg::CIP_ST_NORMAL;
			end
		endcase
	end

	// mode state; warm and cold reset both drop back to normal running
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= cip_pkg::CIP_ST_NORMAL;
		end else if (ctl_sync_ff.warm || cold_busy) begin
			state_ff <= cip_pkg::CIP_ST_NORMAL;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// index register: written at the key address while configuring, never read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			index_ff <= `CIP_INDEX_RESET;
		end else if (cold_busy) begin
			index_ff <= `CIP_INDEX_RESET;
		end else if (port_wr && in_config && (wr_byte != `CIP_KEY_EXIT) && idx_ok) begin
			index_ff <= wr_byte;
		end
	end

	// strap settles through the synchroniser two edges after release
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			strap_cnt_ff <= 2'h0;
		end else if (strap_cnt_ff != 2'h3) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
		end
	end

	// global registers: only power-on or cold reset restores them
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			option_ff <= `CIP_OPTION_RESET;
			ldn_ff    <= `CIP_LDN_RESET;
		end else if (cold_busy || (strap_cnt_ff == 2'h2)) begin
			option_ff <= `CIP_OPTION_RESET;
			option_ff[`CIP_OPT_ADDR_SEL_BIT] <= ctl_sync_ff.strap;
			ldn_ff    <= `CIP_LDN_RESET;
		end else if (cfg_wr && (index_ff == `CIP_IDX_OPTION)) begin
			option_ff <= wr_byte;
		end else if (cfg_wr && (index_ff == `CIP_IDX_LDN)) begin
			ldn_ff    <= wr_byte;
		end
	end

	// soft reset is a one-clock pulse; the register bit reads back as zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			soft_reset_ff <= 1'b0;
		end else begin
			soft_reset_ff <= cfg_wr && (index_ff == `CIP_IDX_SOFT_RESET) &&
			                 wr_byte[`CIP_SOFT_RESET_BIT];
		end
	end

	// per-device banks; warm reset has no path in here at all
	for (genvar d = 0; d < `CIP_NUM_LDN; d++) begin : g_bank
		always_ff @(posedge clock or negedge arst_n) begin
			if (!arst_n) begin
				for (int i = 0; i < `CIP_BANK_DEPTH; i++) begin
					bank_ff[d][i] <= `CIP_BANK_RESET;
				end
			end else if (cold_busy) begin
				for (int i = 0; i < `CIP_BANK_DEPTH; i++) begin
					bank_ff[d][i] <= `CIP_BANK_RESET;
				end
			end else if (cfg_wr && bank_hit && (bank_sel == 4'(d))) begin
				bank_ff[d][bank_off] <= wr_byte;
			end
		end
	end

	// read data captured at the start of a data port read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rd_data_ff <= 8'h00;
		end else if (data_rd) begin
			rd_data_ff <= rd_value;
		end
	end

	// only the data port ever drives; the key/index address stays silent
	assign isa_data_oe  = pin_sync_ff.ior && ior_prev_ff && hit_data && cfg_rd_ok;
	assign isa_data_out = rd_data_ff;

	// status
	assign config_mode            = in_config;
	assign logical_device         = ldn_ff;
	assign global_option_register = option_ff;
	assign soft_reset_pulse       = soft_reset_ff;

endmodule : cip_config_port

`default_nettype wire

// [testbench/cip_chk.sv]
/*
 * timing checker of the configuration port, bound to cip_config_port.
 * assumes it sees the port module's pins only, one clock domain.
 */
`default_nettype none

module cip_chk (
	// clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// host side
	input wire logic [15:0] isa_addr,
	input wire logic [7:0]  isa_data_in,
	input wire logic        isa_ior_n,
	input wire logic        isa_data_oe,
	// straps, resets and status
	input wire logic        address_strap_input,
	input wire logic        master_reset_input,
	input wire logic        warm_reset_input,
	input wire logic        config_mode,
	input wire logic [7:0]  logical_device,
	input wire logic [7:0]  global_option_register,
	input wire logic        soft_reset_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic [3:0] rst_hist_ff;
	// recent warm or cold resets excuse mode and register changes
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) rst_hist_ff <= 4'h0;
		else rst_hist_ff <= {rst_hist_ff[2:0], warm_reset_input | master_reset_input};
	end
	property p_oe_addr;
		isa_data_oe |-> isa_addr == (global_option_register[6] ? 16'h0371 : 16'h03F1)
			&& (!$past(isa_ior_n, 2) || !$past(isa_ior_n, 3));
	endproperty
	a_oe_addr: assert property (p_oe_addr) else $error("read drive off data port");
	property p_oe_cfg;
		isa_data_oe |-> config_mode;
	endproperty
	a_oe_cfg: assert property (p_oe_cfg) else $error("read driven outside mode");
	property p_enter;
		$rose(config_mode) |-> $past(isa_data_in, 3) == 8'h87
			&& $past(isa_addr, 3) == (global_option_register[6] ? 16'h0370 : 16'h03F0);
	endproperty
	a_enter: assert property (p_enter) else $error("mode entered without key");
	property p_exit;
		$fell(config_mode) |-> $past(isa_data_in, 3) == 8'hAA || rst_hist_ff != 4'h0;
	endproperty
	a_exit: assert property (p_exit) else $error("mode left without exit key");
	property p_quiet;
		$changed(logical_device) |-> $past(config_mode) || rst_hist_ff != 4'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("device number changed outside mode");
	property p_strap;
		$rose(arst_n) |-> ##4 global_option_register[6] == address_strap_input;
	endproperty
	a_strap: assert property (p_strap) else $error("strap not latched");
	property p_cold;
		master_reset_input [*4] |-> !config_mode && logical_device == 8'h00 && global_option_register[5:0] == 6'h00;
	endproperty
	a_cold: assert property (p_cold) else $error("cold reset kept state");
	property p_warm;
		warm_reset_input && !master_reset_input |=> $stable(logical_device) && $stable(global_option_register);
	endproperty
	a_warm: assert property (p_warm) else $error("warm reset changed registers");
	property p_pulse;
		soft_reset_pulse |-> config_mode ##1 !soft_reset_pulse;
	endproperty
	a_pulse: assert property (p_pulse) else $error("soft reset pulse wrong");
endmodule : cip_chk

bind cip_config_port cip_chk cip_chk_inst (.clock(clock), .arst_n(arst_n), .isa_addr(isa_addr),
	.isa_data_in(isa_data_in), .isa_ior_n(isa_ior_n), .isa_data_oe(isa_data_oe),
	.address_strap_input(address_strap_input), .master_reset_input(master_reset_input),
	.warm_reset_input(warm_reset_input), .config_mode(config_mode), .logical_device(logical_device),
	.global_option_register(global_option_register), .soft_reset_pulse(soft_reset_pulse));

`default_nettype wire

// [testbench/cip_host.sv]
/*
 * behavioural host making i/o cycles on the port's pins.
 * assumes the bench calls its cyc task, one cycle at a time.
 */
`default_nettype none

module cip_host (
	// clock
	input wire logic         clock,
	// host bus
	output logic      [15:0] isa_addr,
	output logic      [7:0]  isa_data_in,
	output logic             isa_iow_n,
	output logic             isa_ior_n,
	output logic             isa_aen,
	input  wire logic [7:0]  isa_data_out,
	input  wire logic        isa_data_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		isa_addr = 16'h0000;
		isa_data_in = 8'h00;
		isa_iow_n = 1'b1;
		isa_ior_n = 1'b1;
		isa_aen = 1'b0;
	end
	// one i/o cycle; address and data settle a clock before the strobe
	// the bench sequences enter, program, exit in that order
	task automatic cyc(input logic [15:0] a, input logic [7:0] d, input logic rd, output logic [7:0] q);
		// start off the edge, so the port's input flops never race the new address
		@(posedge clock) #1;
		isa_addr = a;
		isa_data_in = d;
		@(posedge clock) #1;
		if (rd) isa_ior_n = 1'b0;
		else isa_iow_n = 1'b0;
		repeat (4) @(posedge clock);
		#1 q = isa_data_oe ? isa_data_out : 8'hZZ;
		isa_ior_n = 1'b1;
		isa_iow_n = 1'b1;
		// hold, then show the inverse so a stale value never matches
		repeat (4) @(posedge clock);
		#1 isa_addr = ~a;
		isa_data_in = ~d;
	endtask : cyc
endmodule : cip_host

`default_nettype wire

// [testbench/test_config_index_port.sv]
/*
 * self-checking bench of the configuration port with a host model.
 * assumes cip_chk is bound to the port module.
 */
`default_nettype none

module test_config_index_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock = 1'b0, arst_n = 1'b0;
	logic        address_strap_input = 1'b0, master_reset_input = 1'b0, warm_reset_input = 1'b0;
	wire  [15:0] isa_addr;
	wire  [7:0]  isa_data_in, isa_data_out, logical_device, global_option_register;
	wire         isa_iow_n, isa_ior_n, isa_aen, isa_data_oe, config_mode, soft_reset_pulse;
	logic [15:0] b = 16'h03F0;
	int          fails = 0, tests_run = 0, cycles = 0, pulses = 0;
	cip_config_port cip_config_port_inst (.clock, .arst_n, .isa_addr, .isa_data_in, .isa_iow_n, .isa_ior_n,
		.isa_aen, .isa_data_out, .isa_data_oe, .address_strap_input, .master_reset_input,
		.warm_reset_input, .config_mode, .logical_device, .global_option_register, .soft_reset_pulse);
	cip_host cip_host_inst (.clock, .isa_addr, .isa_data_in, .isa_iow_n, .isa_ior_n, .isa_aen,
		.isa_data_out, .isa_data_oe);
	always #2 clock = ~clock;
	// soft reset pulses, read mid-cycle where outputs have settled, and a hang limit well above the run
	always @(negedge clock) begin
		cycles++;
		if (soft_reset_pulse === 1'b1) pulses++;
		if (cycles == 8000) begin
			fails++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_sim
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	// bus helpers: w writes, r reads, x indexes and writes, y indexes and reads
	task automatic w(input logic [15:0] a, input logic [7:0] d);
		logic [7:0] q;
		cip_host_inst.cyc(a, d, 1'b0, q);
	endtask : w
	task automatic r(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] q;
		cip_host_inst.cyc(a, 8'h00, 1'b1, q);
		check(q, exp);
	endtask : r
	task automatic x(input logic [7:0] i, input logic [7:0] d);
		w(b, i);
		w(b + 16'h0001, d);
	endtask : x
	task automatic y(input logic [7:0] i, input logic [7:0] exp);
		w(b, i);
		r(b + 16'h0001, exp);
	endtask : y
	task automatic key;
		w(b, 8'h87);
		w(b, 8'h87);
	endtask : key
	// a stray write between keys restarts the sequence
	task automatic t_enter;
		w(b, 8'h87);
		w(b + 16'h0001, 8'h12);
		w(b, 8'h87);
		x(8'h07, 8'h03);
		check(logical_device, 8'h00);
		key();
		check({7'h00, config_mode}, 8'h01);
	endtask : t_enter
	// banks per device, holes, refused index, write-only key port
	task automatic t_bank;
		x(8'h07, 8'h01);
		x(8'hF0, 8'h3C);
		x(8'h07, 8'h02);
		x(8'hF0, 8'h55);
		x(8'h07, 8'h01);
		y(8'hF0, 8'h3C);
		x(8'h07, 8'h04);
		x(8'h30, 8'h77);
		y(8'h30, 8'h00);
		w(b, 8'h07);
		w(b, 8'h05);
		w(b + 16'h0001, 8'h01);
		check(logical_device, 8'h01);
		r(b, 8'hZZ);
		// dma cycles (aen high) must not reach the data port
		cip_host_inst.isa_aen = 1'b1;
		w(b + 16'h0001, 8'h09);
		cip_host_inst.isa_aen = 1'b0;
		check(logical_device, 8'h01);
	endtask : t_bank
	// lock blocks all but the option register; soft reset pulses once
	task automatic t_lock;
		x(8'h26, 8'h20);
		x(8'h07, 8'h02);
		check(logical_device, 8'h01);
		y(8'hF0, 8'hZZ);
		x(8'h26, 8'h00);
		x(8'h02, 8'h01);
		check(pulses[7:0], 8'h01);
		y(8'h02, 8'h00);
	endtask : t_lock
	// warm reset ends the mode only; exit key closes it again
	task automatic t_warm;
		@(posedge clock) #1 warm_reset_input = 1'b1;
		repeat (3) @(posedge clock);
		#1 warm_reset_input = 1'b0;
		repeat (4) @(posedge clock);
		#1 check({7'h00, config_mode}, 8'h00);
		key();
		y(8'hF0, 8'h3C);
		w(b, 8'hAA);
		check({7'h00, config_mode}, 8'h00);
		x(8'h07, 8'h05);
		check(logical_device, 8'h01);
	endtask : t_warm
	// cold reset restores defaults and reloads the address strap
	task automatic t_cold;
		address_strap_input = 1'b1;
		@(posedge clock) #1 master_reset_input = 1'b1;
		repeat (6) @(posedge clock);
		#1 master_reset_input = 1'b0;
		repeat (4) @(posedge clock);
		#1 check(global_option_register, 8'h40);
		check(logical_device, 8'h00);
		key();
		check({7'h00, config_mode}, 8'h00);
		b = 16'h0370;
		key();
		x(8'h07, 8'h01);
		y(8'hF0, 8'h00);
	endtask : t_cold
	initial begin
		repeat (4) @(posedge clock);
		#1 arst_n = 1'b1;
		repeat (6) @(posedge clock);
		#1 check(global_option_register, 8'h00);
		t_enter();
		t_bank();
		t_lock();
		t_warm();
		t_cold();
		end_sim();
	end
endmodule : test_config_index_port

`default_nettype wire
